// >>> hpw_pkg.sv
// Constants and types for the host port, strap latch and window decode
// How it works
// - Four config straps are sampled once after reset and held until next reset.
// - Bus-style strap is latched together with the four config straps.
// - Strap high is 1, low is 0; high bus-style selects shared-high-byte variant.
// - Family straps all ones select the generic bus family; variant from bus-style.
// - Host strobes are asynchronous; they are synchronised before use.
// - Byte-order strap high selects big-endian, low little-endian.
// - Display memory at 0 to 13FFFh, registers at 1FFE0h to 1FFFFh.
// - Wait output held low until arbitration completes, released on data ready.
package hpw_pkg;
  localparam int HPW_ADDR_W = 17;
  localparam int HPW_DATA_W = 16;
  localparam int HPW_STRB_W = 5;
  localparam int HPW_STRAP_W = 5;
  localparam logic [HPW_ADDR_W-1:0] HPW_MEM_LAST = 17'h13FFF;
  localparam logic [HPW_ADDR_W-1:0] HPW_REG_FIRST = 17'h1FFE0;
  localparam logic [2:0] HPW_FAMILY_GENERIC = 3'h7;
  // Strap sync output settles on the fourth edge, so capture on the fifth
  localparam logic [2:0] HPW_STRAP_CAP_CYC = 3'h4;
  // Bit positions in the latched strap vector
  localparam int HPW_BIT_ENDIAN = 3;
  localparam int HPW_BIT_BUS_STYLE = 4;
  // Positions in the synchronised strobe vector
  localparam int HPW_S_CS = 0;
  localparam int HPW_S_RD = 1;
  localparam int HPW_S_RDWR = 2;
  localparam int HPW_S_WE0 = 3;
  localparam int HPW_S_WE1 = 4;
  localparam logic [HPW_STRB_W-1:0] HPW_STRB_IDLE = 5'h1F;
  localparam logic [HPW_STRAP_W-1:0] HPW_STRAP_RST = 5'h00;
  // APB register map
  localparam logic [7:0] HPW_OFS_CONFIG = 8'h00;
  localparam logic [7:0] HPW_OFS_CTRL = 8'h04;
  localparam logic [7:0] HPW_OFS_STATUS = 8'h08;
  localparam logic [7:0] HPW_OFS_LAST = 8'h0C;
  localparam logic [31:0] HPW_CTRL_RST = 32'h00000001;
  localparam int HPW_CTRL_EN = 0;
  localparam int HPW_CFG_DONE = 5;
  localparam int HPW_CFG_FAMOK = 6;
  localparam int HPW_ST_CNT_LSB = 16;
  localparam int HPW_LAST_RGN_LSB = 17;
  localparam int HPW_LAST_WR = 19;
  // Decoded regions
  localparam logic [1:0] HPW_RGN_HOLE = 2'h0;
  localparam logic [1:0] HPW_RGN_MEM = 2'h1;
  localparam logic [1:0] HPW_RGN_REG = 2'h2;

  typedef enum logic [1:0] {
    HPW_IDLE = 2'b00,
    HPW_ARB = 2'b01,
    HPW_DONE = 2'b11
  } hpw_state_t;

  function automatic logic [HPW_DATA_W-1:0] hpw_swap(input logic [HPW_DATA_W-1:0] d,
                                                   input logic big);
    hpw_swap = big ? {d[7:0], d[15:8]} : d;
  endfunction

  function automatic logic [1:0] hpw_region(input logic [HPW_ADDR_W-1:0] a);
    if (a <= HPW_MEM_LAST)
      hpw_region = HPW_RGN_MEM;
    else if (a >= HPW_REG_FIRST)
      hpw_region = HPW_RGN_REG;
    else
      hpw_region = HPW_RGN_HOLE;
  endfunction
endpackage

// >>> hpw_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module hpw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  // Per bit: a change is taken only once stages two and three agree
  assign out_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & out_r);
  assign o_sync = out_r;

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      out_r <= RST_VAL;
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end
endmodule // hpw_sync

// >>> hpw_host_port.sv
// Host port: strap latch, async strobe handling, window decode, wait, APB
`timescale 1ns/100ps
module hpw_host_port
  import hpw_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_config_straps,
  input wire logic i_bus_style_strap,
  input wire logic i_host_cs_n,
  input wire logic i_host_rd_n,
  input wire logic i_host_rdwr_n,
  input wire logic i_host_we0_n,
  input wire logic i_host_we1_n,
  input wire logic [HPW_ADDR_W-1:0] i_host_addr,
  input wire logic [HPW_DATA_W-1:0] i_host_data,
  output logic [HPW_DATA_W-1:0] o_host_data,
  output logic o_host_data_oe,
  output logic o_host_wait_n,
  output logic o_acc_req,
  output logic o_acc_is_reg,
  output logic o_acc_write,
  output logic [1:0] o_acc_be,
  output logic [HPW_ADDR_W-1:0] o_acc_addr,
  output logic [HPW_DATA_W-1:0] o_acc_wdata,
  input wire logic i_acc_ack,
  input wire logic [HPW_DATA_W-1:0] i_acc_rdata,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  logic [HPW_STRAP_W-1:0] strap_sync;
  logic [HPW_STRB_W-1:0] strb_sync;
  logic [HPW_STRAP_W-1:0] cfg_r;
  logic cfg_done_r;
  logic [2:0] cap_cnt_r;
  hpw_state_t state_r;
  hpw_state_t state_nxt;
  logic [HPW_ADDR_W-1:0] addr_r;
  logic [HPW_DATA_W-1:0] wdata_r;
  logic [1:0] be_r;
  logic write_r;
  logic is_reg_r;
  logic [1:0] rgn_r;
  logic [HPW_DATA_W-1:0] rdata_r;
  logic oe_r;
  logic [31:0] ctrl_r;
  logic [15:0] acc_cnt_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  hpw_sync #(.W(HPW_STRAP_W), .RST_VAL(HPW_STRAP_RST)) u_strap_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_bus_style_strap, i_config_straps}),
    .o_sync(strap_sync)
  );

  // Host strobes come from another clock domain
  hpw_sync #(.W(HPW_STRB_W), .RST_VAL(HPW_STRB_IDLE)) u_strb_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_async({i_host_we1_n, i_host_we0_n, i_host_rdwr_n, i_host_rd_n, i_host_cs_n}),
    .o_sync(strb_sync)
  );

  // Latched configuration
  wire cfg_big = cfg_r[HPW_BIT_ENDIAN];
  wire cfg_shared_hi = cfg_r[HPW_BIT_BUS_STYLE];
  wire family_ok = cfg_done_r && (cfg_r[2:0] == HPW_FAMILY_GENERIC);
  wire cap_now = !cfg_done_r && (cap_cnt_r == HPW_STRAP_CAP_CYC);

  // Strobe decode per bus variant
  wire cs = !strb_sync[HPW_S_CS];
  wire rd_lo = !strb_sync[HPW_S_RD];
  wire rd_hi = !strb_sync[HPW_S_RDWR];
  wire we_lo = !strb_sync[HPW_S_WE0];
  wire we_hi = !strb_sync[HPW_S_WE1];
  wire g2_rd = rd_lo;
  wire g2_wr = we_lo;
  wire g1_rd = rd_lo || rd_hi;
  wire g1_wr = we_lo || we_hi;
  wire h_rd = cfg_shared_hi ? g2_rd : g1_rd;
  wire h_wr = cfg_shared_hi ? g2_wr : g1_wr;
  wire host_act = cs && (h_rd || h_wr) && family_ok;
  wire [1:0] g1_be = g1_wr ? {we_hi, we_lo} : {rd_hi, rd_lo};
  wire [1:0] g2_be = {we_hi, !i_host_addr[0]};
  wire [1:0] be_raw = cfg_shared_hi ? g2_be : g1_be;
  wire [1:0] be_ord = cfg_big ? {be_raw[0], be_raw[1]} : be_raw;
  wire [1:0] rgn_now = hpw_region(i_host_addr);
  wire start = (state_r == HPW_IDLE) && host_act;
  wire fwd = (rgn_now != HPW_RGN_HOLE) && ctrl_r[HPW_CTRL_EN];

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      HPW_IDLE:
        if (host_act)
          state_nxt = fwd ? HPW_ARB : HPW_DONE;
      HPW_ARB:
        if (i_acc_ack)
          state_nxt = HPW_DONE;
      HPW_DONE:
        if (!host_act)
          state_nxt = HPW_IDLE;
      default:
        state_nxt = HPW_IDLE;
    endcase
  end

  // Wait stays low from strobe until data are ready or accepted
  assign o_host_wait_n = !(host_act && (state_r != HPW_DONE));
  assign o_acc_req = (state_r == HPW_ARB);
  assign o_acc_is_reg = is_reg_r;
  assign o_acc_write = write_r;
  assign o_acc_be = be_r;
  assign o_acc_addr = addr_r;
  assign o_acc_wdata = wdata_r;
  assign o_host_data = rdata_r;
  assign o_host_data_oe = oe_r;

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cap_cnt_r <= '0;
      cfg_done_r <= 1'b0;
      cfg_r <= HPW_STRAP_RST;
    end
    else if (cap_now)
    begin
      cfg_r <= strap_sync;
      cfg_done_r <= 1'b1;
    end
    else if (!cfg_done_r)
      cap_cnt_r <= cap_cnt_r + 3'h1;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_r <= HPW_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      be_r <= '0;
      write_r <= 1'b0;
      is_reg_r <= 1'b0;
      rgn_r <= HPW_RGN_HOLE;
    end
    else
    begin
      state_r <= state_nxt;
      if (start)
      begin
        addr_r <= i_host_addr;
        wdata_r <= hpw_swap(i_host_data, cfg_big);
        be_r <= be_ord;
        write_r <= h_wr;
        is_reg_r <= (rgn_now == HPW_RGN_REG);
        rgn_r <= fwd ? rgn_now : HPW_RGN_HOLE;
      end
    end
  end

  // Holes and disabled accesses read back zero
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_r <= '0;
      oe_r <= 1'b0;
    end
    else
    begin
      if (state_r == HPW_ARB && i_acc_ack)
        rdata_r <= hpw_swap(i_acc_rdata, cfg_big);
      else if (start && !fwd)
        rdata_r <= '0;
      // A new access decides the direction itself, not the stale write_r
      oe_r <= (state_nxt == HPW_DONE) && (start ? !h_wr : !write_r);
    end
  end

  // APB: data prepared in setup, answer in the first access cycle
  wire apb_setup = i_psel && !i_penable;
  wire apb_wr = i_psel && i_penable && i_pwrite;
  wire [31:0] cfg_word = {25'h0, family_ok, cfg_done_r, cfg_r};
  wire [31:0] st_word = {acc_cnt_r, 14'h0, o_acc_req, state_r != HPW_IDLE};
  wire [31:0] last_word = {12'h0, write_r, rgn_r, addr_r};
  wire map_hit = (i_paddr == HPW_OFS_CONFIG) || (i_paddr == HPW_OFS_CTRL) ||
                 (i_paddr == HPW_OFS_STATUS) || (i_paddr == HPW_OFS_LAST);
  wire [31:0] rd_mux = (i_paddr == HPW_OFS_CONFIG) ? cfg_word :
                       (i_paddr == HPW_OFS_CTRL) ? ctrl_r :
                       (i_paddr == HPW_OFS_STATUS) ? st_word :
                       (i_paddr == HPW_OFS_LAST) ? last_word : 32'h00000000;

  assign o_pready = i_psel && i_penable;
  assign o_prdata = prdata_r;
  assign o_pslverr = pslverr_r && i_psel && i_penable;

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ctrl_r <= HPW_CTRL_RST;
      prdata_r <= '0;
      pslverr_r <= 1'b0;
      acc_cnt_r <= '0;
    end
    else
    begin
      if (apb_setup)
      begin
        prdata_r <= i_pwrite ? 32'h00000000 : rd_mux;
        pslverr_r <= !map_hit;
      end
      if (apb_wr && i_paddr == HPW_OFS_CTRL)
        ctrl_r <= {31'h0, i_pwdata[HPW_CTRL_EN]};
      if (state_r != HPW_DONE && state_nxt == HPW_DONE)
        acc_cnt_r <= acc_cnt_r + 16'h0001;
    end
  end

  strap_stable_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cfg_done_r && $past(cfg_done_r) |-> $stable(cfg_r) && cfg_done_r)
    else $error("latched straps changed after capture");

  strap_capture_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(cfg_done_r) |-> cfg_r == $past(strap_sync))
    else $error("bus-style or config strap not captured");

  family_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(o_acc_req) |-> cfg_r[2:0] == HPW_FAMILY_GENERIC)
    else $error("access forwarded without generic family straps");

  variant_rd_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(o_acc_req) && cfg_shared_hi |-> $past(rd_lo || we_lo))
    else $error("shared-high-byte variant took a split-strobe access");

  async_start_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    $rose(o_acc_req) |-> $past(cs) && $past(state_r) == HPW_IDLE)
    else $error("access started without a synchronised strobe");

  wait_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_req && !i_acc_ack && host_act |-> !o_host_wait_n)
    else $error("wait released before arbitration finished");

  wait_release_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_req && i_acc_ack |=> o_host_wait_n && (oe_r == !write_r))
    else $error("wait not released one cycle after grant");

  decode_win_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_req |-> (o_acc_is_reg ? (o_acc_addr >= HPW_REG_FIRST)
                                : (o_acc_addr <= HPW_MEM_LAST)))
    else $error("access forwarded outside memory or register window");

  endian_rd_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_req && i_acc_ack && cfg_big |=> rdata_r == {$past(i_acc_rdata[7:0]),
                                                     $past(i_acc_rdata[15:8])})
    else $error("big-endian read data not byte swapped");

  cov_gen2_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_req && i_acc_ack && cfg_shared_hi);
  cov_gen1_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_req && i_acc_ack && !cfg_shared_hi);
  cov_hole_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    start && !fwd);
  cov_wait_c: cover property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_acc_req && !i_acc_ack ##1 o_acc_req && !i_acc_ack ##1 i_acc_ack);
endmodule // hpw_host_port

// >>> hpw_host_model.sv
// Host side model: slot window decoder and strobe driver
`timescale 1ns/100ps
module hpw_host_model
  import hpw_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_host_wait_n,
  input wire logic i_host_data_oe,
  input wire logic [HPW_DATA_W-1:0] i_host_data,
  output logic o_cs_n = 1'b1,
  output logic [3:0] o_strb_n = 4'hF,
  output logic [HPW_ADDR_W-1:0] o_addr = '0,
  output logic [HPW_DATA_W-1:0] o_data = '0
);
  // Strobes are {we1_n, we0_n, rdwr_n, rd_n}
  task automatic xfer(input logic [31:0] sa, input logic [3:0] sn,
                      input logic [HPW_DATA_W-1:0] d, output logic [HPW_DATA_W-1:0] q,
                      output logic seen);
    int n;
    begin
      seen = 1'b0;
      n = 0;
      @(posedge i_core_clk);
      o_cs_n <= (sa[31:24] != 8'h09);
      o_addr <= sa[HPW_ADDR_W-1:0];
      o_data <= d;
      o_strb_n <= sn;
      while (!seen && n < 12)
      begin
        @(posedge i_core_clk);
        seen = (i_host_wait_n === 1'b0);
        n++;
      end
      // Wait is bounded so a stuck device cannot hang the host
      while (seen && i_host_wait_n !== 1'b1 && n < 200)
      begin
        @(posedge i_core_clk);
        n++;
      end
      // An undriven bus reads back as the inverse, never as valid data
      q = i_host_data_oe ? i_host_data : ~i_host_data;
      if (n >= 200)
      begin
        seen = 1'bx;
        q = 'x;
      end
      o_cs_n <= 1'b1;
      o_strb_n <= 4'hF;
      // Released lines show noise, not the last value
      o_addr <= ~sa[HPW_ADDR_W-1:0];
      o_data <= ~d;
      repeat (8) @(posedge i_core_clk);
    end
  endtask
endmodule // hpw_host_model

// >>> tb_top.sv
// Self-checking bench for the host port
`timescale 1ns/100ps
module tb_top
  import hpw_pkg::*;
;
  logic clk, nrst, bstyle, cs_n, hoe, wait_n, req, isreg, accw, ack, seen, rerr;
  logic psel, penable, pwrite, pready, perr;
  logic [3:0] straps, sn;
  logic [1:0] be;
  logic [HPW_ADDR_W-1:0] ha, aa;
  logic [HPW_DATA_W-1:0] hw, hr, aw, ar, q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [36:0] cap;
  int mismatches, n_checks, cyc, n_acks, arb_cnt, k;

  hpw_host_model host (.i_core_clk(clk), .i_host_wait_n(wait_n), .i_host_data_oe(hoe),
    .i_host_data(hr), .o_cs_n(cs_n), .o_strb_n(sn), .o_addr(ha), .o_data(hw));

  hpw_host_port dut (.i_core_clk(clk), .i_nrst(nrst), .i_config_straps(straps),
    .i_bus_style_strap(bstyle), .i_host_cs_n(cs_n), .i_host_rd_n(sn[0]), .i_host_rdwr_n(sn[1]),
    .i_host_we0_n(sn[2]), .i_host_we1_n(sn[3]), .i_host_addr(ha), .i_host_data(hw),
    .o_host_data(hr), .o_host_data_oe(hoe), .o_host_wait_n(wait_n), .o_acc_req(req),
    .o_acc_is_reg(isreg), .o_acc_write(accw), .o_acc_be(be), .o_acc_addr(aa),
    .o_acc_wdata(aw), .i_acc_ack(ack), .i_acc_rdata(ar), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Arbiter stand-in: stalls three cycles so the wait must hold
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      give_verdict();
    end
    ack <= 1'b0;
    ar <= ~16'h1234;
    if (req === 1'b1)
      chk(40'(wait_n), 40'h0);
    if (req === 1'b1 && ack !== 1'b1 && ++arb_cnt == 3)
    begin
      ack <= 1'b1;
      ar <= 16'h1234;
      cap <= {isreg, accw, be, aa, aw};
      arb_cnt = 0;
      n_acks++;
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
        @(posedge clk);
      while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1)
        mismatches++;
      rd = prdata;
      rerr = perr;
      {psel, penable} <= 2'b00;
    end
  endtask

  task automatic do_reset(input logic [3:0] s, input logic b);
    @(posedge clk);
    nrst <= 1'b0;
    straps <= s;
    bstyle <= b;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (12) @(posedge clk);
  endtask

  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {straps, bstyle} = 5'h1F;
    do_reset(4'hF, 1'b1);
    apb(1'b0, HPW_OFS_CONFIG, 32'h0);
    chk(40'(rd[6:0]), 40'h7F);
    {straps, bstyle} <= 5'h00;
    apb(1'b1, HPW_OFS_CONFIG, 32'h0);
    // Let the new strap levels pass the synchroniser first
    repeat (8) @(posedge clk);
    apb(1'b0, HPW_OFS_CONFIG, 32'h0);
    chk(40'(rd[6:0]), 40'h7F);
    apb(1'b0, 8'h10, 32'h0);
    chk(40'({rerr, rd}), 40'h1_0000_0000);
    apb(1'b0, HPW_OFS_CTRL, 32'h0);
    chk(40'(rd), 40'(HPW_CTRL_RST));
    // Alias of the window, low byte only; big-endian swaps lanes
    host.xfer(32'h0912_0010, 4'b1011, 16'hA55A, q, seen);
    chk(40'({seen, cap}), 40'({1'b1, 1'b0, 1'b1, 2'b10, 17'h00010, 16'h5AA5}));
    host.xfer(32'h0901_FFE2, 4'b0110, 16'h0, q, seen);
    chk(40'({q, cap[36:16]}), 40'({16'h3412, 4'b1011, 17'h1FFE2}));
    k = n_acks;
    host.xfer(32'h0901_4000, 4'b0110, 16'h0, q, seen);
    apb(1'b0, HPW_OFS_LAST, 32'h0);
    chk(40'({seen, q, 8'(n_acks - k)}), 40'({1'b1, 24'h0}));
    chk(40'(rd[HPW_LAST_WR:0]), 40'({1'b0, HPW_RGN_HOLE, 17'h14000}));
    host.xfer(32'h0A00_0010, 4'b0110, 16'h0, q, seen);
    chk(40'(seen), 40'h0);
    apb(1'b1, HPW_OFS_CTRL, 32'h0);
    k = n_acks;
    host.xfer(32'h0900_0010, 4'b0110, 16'h0, q, seen);
    chk(40'({q, 8'(n_acks - k)}), 40'h0);
    // Two forwarded, one hole and one disabled access have completed
    apb(1'b0, HPW_OFS_STATUS, 32'h0);
    chk(40'(rd), 40'h0_0004_0000);
    apb(1'b1, HPW_OFS_CTRL, 32'h1);
    // Split-strobe variant, little-endian, second reset in mid-run
    do_reset(4'h7, 1'b0);
    apb(1'b0, HPW_OFS_CONFIG, 32'h0);
    chk(40'(rd[6:0]), 40'h67);
    host.xfer(32'h0900_0020, 4'b0111, 16'hA55A, q, seen);
    chk(40'(cap), 40'({2'b01, 2'b10, 17'h00020, 16'hA55A}));
    host.xfer(32'h0900_0020, 4'b1100, 16'h0, q, seen);
    chk(40'({q, cap[36:16]}), 40'({16'h1234, 4'b0011, 17'h00020}));
    do_reset(4'hE, 1'b1);
    apb(1'b0, HPW_OFS_CONFIG, 32'h0);
    chk(40'(rd[6:0]), 40'h3E);
    k = n_acks;
    host.xfer(32'h0900_0010, 4'b0110, 16'h0, q, seen);
    chk(40'({seen, 8'(n_acks - k)}), 40'h0);
    give_verdict();
  end
endmodule // tb_top
